// File: shared/hip_defs.svh
/*
  Holds the offsets, field values, reset values and timing counts of the
  host i/o port. Assumes a 10 MHz system clock; included by bare name.
*/
`ifndef HIP_DEFS_SVH
`define HIP_DEFS_SVH

`define HIP_CLK_PERIOD_NS 100
`define HIP_BLACKOUT_NS 3000000
`define HIP_BLACKOUT_CYC (`HIP_BLACKOUT_NS / `HIP_CLK_PERIOD_NS)
`define HIP_EEPROM_CHIP_SELECT_DELAY_PS 11310000
`define HIP_EEPROM_CHIP_SELECT_DELAY_CYC \
  ((`HIP_EEPROM_CHIP_SELECT_DELAY_PS + `HIP_CLK_PERIOD_NS * 1000 - 1) / \
   (`HIP_CLK_PERIOD_NS * 1000))

`define HIP_RD_REG_GAP 8'h02
`define HIP_RD_F0_SPACING 8'h04
`define HIP_RD_F2_SPACING 8'h01
`define HIP_WR_IDX_GAP 8'h01
`define HIP_WR_DATA_GAP 8'h02
`define HIP_WR_MEM_SPACING 8'h01

`define HIP_IDX_MEM_F0 8'hf0
`define HIP_IDX_MEM_F2 8'hf2
`define HIP_IDX_MEM_F6 8'hf6
`define HIP_IDX_MEM_F8 8'hf8

`define HIP_INDEX_RST 8'h00
`define HIP_DATA_RST 32'h0000_0000
`define HIP_BASE_ADDR 4'h0

`endif

// File: shared/hip_pkg.sv
/*
  Types of the host i/o port: bus width, load state, access kind.
  Assumes nothing beyond the defines header.
*/
package hip_pkg;

  typedef enum logic [1:0] {
    HIP_BUS8 = 2'h0,
    HIP_BUS16 = 2'h1,
    HIP_BUS32 = 2'h2
  } hip_width_t;

  typedef enum logic [1:0] {
    HIP_LOADING = 2'b01,
    HIP_READY = 2'b10
  } hip_state_t;

  typedef enum logic [6:0] {
    HIP_AK_NONE = 7'b0000001,
    HIP_AK_RD_REG = 7'b0000010,
    HIP_AK_RD_F0 = 7'b0000100,
    HIP_AK_RD_F2 = 7'b0001000,
    HIP_AK_WR_IDX = 7'b0010000,
    HIP_AK_WR_DATA = 7'b0100000,
    HIP_AK_WR_MEM = 7'b1000000
  } hip_kind_t;

endpackage

// File: shared/hip_pin_if.sv
/*
  Carries the host pins after synchronisation from the synchroniser to the
  port logic. Assumes both ends run on the same system clock.
*/
interface hip_pin_if;
  logic readN;
  logic writeN;
  logic aenN;
  logic cmd;
  logic [3:0] addr;
  logic [31:0] data;
  logic [1:0] width;

  modport src (output readN, writeN, aenN, cmd, addr, data, width);
  modport dst (input readN, writeN, aenN, cmd, addr, data, width);
endinterface

// File: src/hip_pin_sync.sv
/*
  Two-flop synchronisers for every host pin of the port.
  Assumes the pins are asynchronous to clk; idle levels are strobes high.
*/
module hip_pin_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic addressEnableN,
  input wire logic indexDataSel,
  input wire logic [3:0] hostAddr,
  input wire logic [31:0] hostDataIn,
  input wire logic [1:0] busWidthSel,
  hip_pin_if.src pins
);

  localparam int W = 1 + 1 + 1 + 1 + 4 + 32 + 2;
  localparam logic [W-1:0] IDLE = {3'b111, {(W - 3){1'b0}}};

  logic [W-1:0] raw;
  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;

  assign raw = {readStrobeN, writeStrobeN, addressEnableN, indexDataSel,
                hostAddr, hostDataIn, busWidthSel};

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : gBit
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stage1_q[g] <= IDLE[g];
          stage2_q[g] <= IDLE[g];
        end else begin
          stage1_q[g] <= raw[g];
          stage2_q[g] <= stage1_q[g];
        end
      end
    end
  endgenerate

  assign {pins.readN, pins.writeN, pins.aenN, pins.cmd, pins.addr,
          pins.data, pins.width} = stage2_q;

endmodule

// File: src/hip_port.sv
/*
  Host index/data i/o port: post-reset load blackout, eeprom select timing,
  index latch, data-port access and width indications, recovery monitor.
  Assumes reset_n is the power-on reset pin and registers sit outside.
*/
// What this block does
// RQ1: ignore host strobes for 3 ms after reset
// RQ2: host waits 3 ms before first access
// RQ3: raise eeprom select 11.31 us after reset
// RQ4: recovery times counted in system clocks
// RQ5: register read end, two clocks gap
// RQ6: f0h memory reads start four clocks apart
// RQ7: f2h memory reads accepted one clock apart
// RQ8: index write end, one clock gap
// RQ9: data write end, two clocks gap
// RQ10: memory writes accepted one clock apart
// RQ11: select high means data port, else index
// RQ12: 16-bit indication on memory index, wide bus
// RQ13: 32-bit indication on memory index, 32-bit bus
// RQ14: index write latches target of data accesses
`include "hip_defs.svh"

module hip_port #(
  parameter int BLACKOUT_CYCLES = `HIP_BLACKOUT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic address_enable_n,
  input wire logic indexDataSel,
  input wire logic [3:0] host_addr,
  input wire logic [31:0] host_data_in,
  output logic [31:0] host_data_out,
  output logic host_data_oe_n,
  input wire logic [1:0] busWidthSel,
  output logic width16_indicate,
  output logic width32_indicate,
  output logic eeprom_chip_select,
  output logic loadDone,
  output logic [7:0] regIndex,
  output logic regWriteStrobe,
  output logic [31:0] regWriteData,
  output logic regReadStrobe,
  input wire logic [31:0] regReadData,
  output logic hostTimingError
);

  localparam int EEPROM_CHIP_SELECT_CYCLES = `HIP_EEPROM_CHIP_SELECT_DELAY_CYC;

  function automatic logic isMemIndex(input logic [7:0] idx);
    isMemIndex = (idx == `HIP_IDX_MEM_F0) || (idx == `HIP_IDX_MEM_F2) ||
                 (idx == `HIP_IDX_MEM_F6) || (idx == `HIP_IDX_MEM_F8);
  endfunction

  hip_pin_if pins ();

  hip_pin_sync uSync (
    .clk(clk),
    .reset_n(reset_n),
    .readStrobeN(read_strobe_n),
    .writeStrobeN(write_strobe_n),
    .addressEnableN(address_enable_n),
    .indexDataSel(indexDataSel),
    .hostAddr(host_addr),
    .hostDataIn(host_data_in),
    .busWidthSel(busWidthSel),
    .pins(pins)
  );

  hip_pkg::hip_state_t state_q;
  logic [31:0] loadCnt_q;
  hip_pkg::hip_width_t width_q;
  logic widthTaken_q;

  // RQ1: load blackout counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= hip_pkg::HIP_LOADING;
      loadCnt_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        hip_pkg::HIP_LOADING: begin
          if (loadCnt_q >= 32'(BLACKOUT_CYCLES - 1)) begin
            state_q <= hip_pkg::HIP_READY;
          end
          loadCnt_q <= loadCnt_q + 32'h0000_0001;
        end
        hip_pkg::HIP_READY: begin
          state_q <= hip_pkg::HIP_READY;
        end
        default: begin
          state_q <= hip_pkg::HIP_LOADING;
          loadCnt_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // RQ3: eeprom select during download
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eeprom_chip_select <= 1'b0;
    end else begin
      eeprom_chip_select <= (state_q == hip_pkg::HIP_LOADING) &&
                            (loadCnt_q >= 32'(EEPROM_CHIP_SELECT_CYCLES - 1)) &&
                            (loadCnt_q < 32'(BLACKOUT_CYCLES - 1));
    end
  end

  assign loadDone = (state_q == hip_pkg::HIP_READY);

  // bus width strap caught once after release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      width_q <= hip_pkg::HIP_BUS8;
      widthTaken_q <= 1'b0;
    end else if (!widthTaken_q && loadCnt_q >= 32'h0000_0002) begin
      width_q <= hip_pkg::hip_width_t'(pins.width);
      widthTaken_q <= 1'b1;
    end
  end

  logic rdPrev_q;
  logic wrPrev_q;
  logic selected;
  logic rdStart;
  logic rdEnd;
  logic wrStart;
  logic wrEnd;

  // RQ1: strobes gated until load done
  assign selected = loadDone && !pins.aenN && (pins.addr == `HIP_BASE_ADDR);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdPrev_q <= 1'b1;
      wrPrev_q <= 1'b1;
    end else begin
      rdPrev_q <= pins.readN;
      wrPrev_q <= pins.writeN;
    end
  end

  assign rdStart = selected && rdPrev_q && !pins.readN;
  assign rdEnd = selected && !rdPrev_q && pins.readN;
  assign wrStart = selected && wrPrev_q && !pins.writeN;
  assign wrEnd = selected && !wrPrev_q && pins.writeN;

  logic [7:0] index_q;
  logic [31:0] wrData_q;
  logic [31:0] wrCommit_q;
  logic wrCommitValid_q;
  logic wrIsData_q;

  // capture data while the write strobe is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrData_q <= `HIP_DATA_RST;
      wrIsData_q <= 1'b0;
    end else if (!pins.writeN) begin
      wrData_q <= pins.data;
      wrIsData_q <= pins.cmd;
    end
  end

  // RQ11: cmd high selects data port
  // RQ14: index write latches the index
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      index_q <= `HIP_INDEX_RST;
    end else if (wrEnd && !wrIsData_q) begin
      index_q <= wrData_q[7:0];
    end
  end

  // RQ14: data write goes to latched index
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrCommitValid_q <= 1'b0;
      wrCommit_q <= `HIP_DATA_RST;
    end else begin
      wrCommitValid_q <= wrEnd && wrIsData_q;
      if (wrEnd) begin
        wrCommit_q <= wrData_q;
      end
    end
  end

  assign regIndex = index_q;
  assign regWriteStrobe = wrCommitValid_q;
  assign regWriteData = wrCommit_q;

  logic rdPending_q;
  logic rdIsData_q;
  logic driving_q;

  // read: strobe once, take answer in the strobe cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdPending_q <= 1'b0;
      rdIsData_q <= 1'b0;
    end else begin
      rdPending_q <= rdStart;
      if (rdStart) begin
        rdIsData_q <= pins.cmd;
      end
    end
  end

  assign regReadStrobe = rdPending_q && rdIsData_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_data_out <= `HIP_DATA_RST;
    end else if (rdPending_q) begin
      host_data_out <= rdIsData_q ? regReadData : {24'h00_0000, index_q};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      driving_q <= 1'b0;
    end else begin
      driving_q <= selected && !pins.readN;
    end
  end

  assign host_data_oe_n = !driving_q;

  // RQ12: 16-bit width indication
  // RQ13: 32-bit width indication
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      width16_indicate <= 1'b0;
      width32_indicate <= 1'b0;
    end else begin
      width16_indicate <= selected && pins.cmd && isMemIndex(index_q) &&
                          (width_q == hip_pkg::HIP_BUS16 ||
                           width_q == hip_pkg::HIP_BUS32);
      width32_indicate <= selected && pins.cmd && isMemIndex(index_q) &&
                          (width_q == hip_pkg::HIP_BUS32);
    end
  end

  hip_pkg::hip_kind_t lastKind_q;
  logic [7:0] sinceStart_q;
  logic [7:0] sinceEnd_q;
  logic newStart;
  logic tooSoon;
  hip_pkg::hip_kind_t startKind;

  assign newStart = rdStart || wrStart;

  always_comb begin
    startKind = hip_pkg::HIP_AK_NONE;
    if (rdStart) begin
      if (!pins.cmd || !isMemIndex(index_q)) begin
        startKind = hip_pkg::HIP_AK_RD_REG;
      end else if (index_q == `HIP_IDX_MEM_F0) begin
        startKind = hip_pkg::HIP_AK_RD_F0;
      end else begin
        startKind = hip_pkg::HIP_AK_RD_F2;
      end
    end else if (wrStart) begin
      if (!pins.cmd) begin
        startKind = hip_pkg::HIP_AK_WR_IDX;
      end else if (isMemIndex(index_q)) begin
        startKind = hip_pkg::HIP_AK_WR_MEM;
      end else begin
        startKind = hip_pkg::HIP_AK_WR_DATA;
      end
    end
  end

  // RQ4: spacing checked in clock cycles
  always_comb begin
    tooSoon = 1'b0;
    case (lastKind_q)
      // RQ5: register read recovery
      hip_pkg::HIP_AK_RD_REG: tooSoon = sinceEnd_q < `HIP_RD_REG_GAP;
      // RQ6: f0h start-to-start spacing
      hip_pkg::HIP_AK_RD_F0: tooSoon = sinceStart_q < `HIP_RD_F0_SPACING;
      // RQ7: f2h back-to-back allowed
      hip_pkg::HIP_AK_RD_F2: tooSoon = sinceStart_q < `HIP_RD_F2_SPACING;
      // RQ8: index write recovery
      hip_pkg::HIP_AK_WR_IDX: tooSoon = sinceEnd_q < `HIP_WR_IDX_GAP;
      // RQ9: data write recovery
      hip_pkg::HIP_AK_WR_DATA: tooSoon = sinceEnd_q < `HIP_WR_DATA_GAP;
      // RQ10: memory writes back-to-back
      hip_pkg::HIP_AK_WR_MEM: tooSoon = sinceStart_q < `HIP_WR_MEM_SPACING;
      hip_pkg::HIP_AK_NONE: tooSoon = 1'b0;
      default: tooSoon = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastKind_q <= hip_pkg::HIP_AK_NONE;
      sinceStart_q <= 8'hff;
      sinceEnd_q <= 8'hff;
      hostTimingError <= 1'b0;
    end else begin
      hostTimingError <= newStart && tooSoon;
      if (newStart) begin
        lastKind_q <= startKind;
        sinceStart_q <= 8'h01;
      end else if (sinceStart_q != 8'hff) begin
        sinceStart_q <= sinceStart_q + 8'h01;
      end
      // end edge is the first idle cycle
      if (rdEnd || wrEnd) begin
        sinceEnd_q <= 8'h01;
      end else if (newStart) begin
        sinceEnd_q <= 8'h00;
      end else if (sinceEnd_q != 8'hff) begin
        sinceEnd_q <= sinceEnd_q + 8'h01;
      end
    end
  end

endmodule

// File: tb/hip_port_checker.sv
/*
  Assertions on the host i/o port outputs against its inputs.
  Assumes it is bound into hip_port and given the same blackout length.
*/
module hip_port_checker #(
  parameter int BLACKOUT_CYCLES = 30000
) (
  input logic clk,
  input logic reset_n,
  input logic indexDataSel,
  input logic [1:0] busWidthSel,
  input logic [31:0] regReadData,
  input logic [31:0] host_data_out,
  input logic host_data_oe_n,
  input logic width16_indicate,
  input logic width32_indicate,
  input logic eeprom_chip_select,
  input logic loadDone,
  input logic [7:0] regIndex,
  input logic regWriteStrobe,
  input logic regReadStrobe,
  input logic hostTimingError
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  int cycQ;
  // cycles since reset release, saturating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cycQ <= 0;
    else if (cycQ < 1000000) cycQ <= cycQ + 1;
  end
  sequence rdSeq;
    !host_data_oe_n ##1 !regReadStrobe;
  endsequence
  AST_QUIET:
    assert property (!loadDone |-> !regWriteStrobe && !regReadStrobe)
    else $error("access taken while loading");
  AST_LOAD_LEN:
    assert property ($rose(loadDone) |-> cycQ >= BLACKOUT_CYCLES - 1
      && cycQ <= BLACKOUT_CYCLES + 2) else $error("blackout length");
  AST_EEPROM_CHIP_SELECT_RISE:
    assert property ($rose(eeprom_chip_select) |-> cycQ inside {[112:116]})
    else $error("eeprom select rise time");
  AST_EEPROM_CHIP_SELECT_EARLY:
    assert property (cycQ < 110 |-> !eeprom_chip_select)
    else $error("eeprom select early");
  AST_W16:
    assert property (width16_indicate |-> busWidthSel != 2'h0 &&
      regIndex inside {8'hf0, 8'hf2, 8'hf6, 8'hf8})
    else $error("16-bit indication wrong");
  AST_W32:
    assert property (width32_indicate |-> busWidthSel == 2'h2
      && width16_indicate) else $error("32-bit indication wrong");
  AST_W_CMD:
    assert property (width16_indicate |-> $past(indexDataSel, 2) ||
      $past(indexDataSel, 3) || $past(indexDataSel, 4))
    else $error("indication without data port");
  AST_RD_DATA:
    assert property (regReadStrobe |=> host_data_out == $past(regReadData))
    else $error("read data not returned");
  AST_RD_DRIVE:
    assert property (regReadStrobe |-> rdSeq)
    else $error("read drive or pulse wrong");
  AST_ERR_LOADED:
    assert property (hostTimingError |-> loadDone && $past(loadDone))
    else $error("timing flag while loading");
endmodule

// File: tb/hip_host_model.sv
/*
  Host bus master model: one strobe per access, then a recovery gap.
  Assumes a caller task invocation per access; drives on rising edges.
*/
module hip_host_model (
  input logic clk,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic address_enable_n,
  output logic indexDataSel,
  output logic [3:0] host_addr,
  output logic [31:0] host_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    address_enable_n = 1'b1;
    indexDataSel = 1'b0;
    host_addr = 4'hf;
    host_data_in = 32'h0;
  end
  task automatic access(input logic wr, input logic sel,
      input logic [31:0] d, input int gap);
    @(posedge clk);
    address_enable_n <= 1'b0;
    host_addr <= 4'h0;
    indexDataSel <= sel;
    host_data_in <= wr ? d : ~d;
    read_strobe_n <= wr;
    write_strobe_n <= !wr;
    @(posedge clk);
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    host_data_in <= ~d;
    repeat (gap) @(posedge clk);
  endtask
endmodule

// File: tb/tb.sv
/*
  Self-checking bench of the host i/o port with a host model.
  Assumes a short blackout parameter so each reset stays brief.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BLACKOUT_CYCLES = 300;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] busWidthSel = 2'h0;
  logic [31:0] regReadData = 32'h0;
  logic read_strobe_n, write_strobe_n, address_enable_n, indexDataSel;
  logic [3:0] host_addr;
  logic [31:0] host_data_in, host_data_out, regWriteData, wrSeen;
  logic host_data_oe_n, width16_indicate, width32_indicate;
  logic eeprom_chip_select, loadDone, regWriteStrobe, regReadStrobe;
  logic hostTimingError;
  logic [7:0] regIndex;
  logic [31:0] lfsrQ = 32'h74ba582f;
  logic [7:0] tIdx [8] = '{8'h05, 8'h05, 8'hf0, 8'hf0, 8'hf0, 8'hf2,
    8'h05, 8'h05};
  logic tWr [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic tSel [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  int tGap [8] = '{0, 1, 0, 0, 2, 0, 0, 0};
  logic tErr [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int err_total = 0;
  int compares = 0;
  int errCnt = 0;
  hip_port #(.BLACKOUT_CYCLES(BLACKOUT_CYCLES)) hip_port_inst (.clk,
    .reset_n, .read_strobe_n, .write_strobe_n, .address_enable_n,
    .indexDataSel, .host_addr, .host_data_in, .host_data_out,
    .host_data_oe_n, .busWidthSel, .width16_indicate, .width32_indicate,
    .eeprom_chip_select, .loadDone, .regIndex, .regWriteStrobe,
    .regWriteData, .regReadStrobe, .regReadData, .hostTimingError);
  hip_host_model hip_host_model_inst (.clk, .read_strobe_n,
    .write_strobe_n, .address_enable_n, .indexDataSel, .host_addr,
    .host_data_in);
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (regWriteStrobe === 1'b1) wrSeen <= regWriteData;
    if (hostTimingError === 1'b1) errCnt++;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic is_mem(input logic [7:0] i);
    return i inside {8'hf0, 8'hf2, 8'hf6, 8'hf8};
  endfunction
  task automatic end_of_test;
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rnd;
    lfsrQ = lfsr_next(lfsrQ);
  endtask
  task automatic do_reset(input logic [1:0] w);
    int n;
    @(posedge clk);
    reset_n <= 1'b0;
    busWidthSel <= w;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    n = 0;
    while (eeprom_chip_select !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check("eeprom_chip_select delay", n inside {[112:116]}, 1);
    if (n >= 400) end_of_test();
    hip_host_model_inst.access(1'b1, 1'b0, 32'h5a, 2);
    while (loadDone !== 1'b1 && n < BLACKOUT_CYCLES + 50) begin
      @(negedge clk);
      n++;
    end
    check("load done", loadDone, 1);
    if (loadDone !== 1'b1) end_of_test();
    check("index ignored", regIndex, 8'h00);
    check("eeprom_chip_select end", eeprom_chip_select, 0);
    repeat (3) @(posedge clk);
  endtask
  initial begin
    logic [31:0] d;
    int e;
    for (int w = 0; w < 3; w++) begin
      do_reset(w[1:0]);
      hip_host_model_inst.access(1'b1, 1'b0, 32'hf0, 6);
      check("index latch", regIndex, 8'hf0);
      check("w16 index port", width16_indicate, 0);
      rnd();
      d = lfsrQ;
      hip_host_model_inst.access(1'b1, 1'b1, d, 6);
      check("write data", wrSeen, d);
      rnd();
      regReadData <= lfsrQ;
      hip_host_model_inst.access(1'b0, 1'b1, 32'h0, 6);
      check("read data", host_data_out, lfsrQ);
      check("w16", width16_indicate, w != 0);
      check("w32", width32_indicate, w == 2);
      rnd();
      d = {24'h0, 1'b0, lfsrQ[6:0]};
      hip_host_model_inst.access(1'b1, 1'b0, d, 6);
      hip_host_model_inst.access(1'b0, 1'b1, 32'h0, 6);
      check("w16 reg index", width16_indicate, is_mem(d[7:0]));
      check("w32 reg index", width32_indicate, 0);
      hip_host_model_inst.access(1'b0, 1'b0, 32'h0, 6);
      check("index read", host_data_out, d);
    end
    for (int k = 0; k < 8; k++) begin
      hip_host_model_inst.access(1'b1, 1'b0, {24'h0, tIdx[k]}, 6);
      e = errCnt;
      rnd();
      hip_host_model_inst.access(tWr[k], tSel[k], lfsrQ, tGap[k]);
      hip_host_model_inst.access(tWr[k], tSel[k], ~lfsrQ, 6);
      check("spacing flag", errCnt != e, tErr[k]);
    end
    end_of_test();
  end
endmodule

bind hip_port hip_port_checker #(.BLACKOUT_CYCLES(BLACKOUT_CYCLES))
  hip_port_checker_inst (.clk, .reset_n, .indexDataSel, .busWidthSel,
  .regReadData, .host_data_out, .host_data_oe_n, .width16_indicate,
  .width32_indicate, .eeprom_chip_select, .loadDone, .regIndex,
  .regWriteStrobe, .regReadStrobe, .hostTimingError);
